//--- core/jiap_pkg.sv
// Package: register map, field layout and carrier types of the indirect port
package jiap_pkg;
    // ************************************************************
    // Register offsets on the internal register bus
    // ************************************************************
    localparam logic [7:0] CTRL_OFFSET       = 8'h1e;
    localparam logic [7:0] DATA_OFFSET       = 8'h1f;
    localparam logic [7:0] ALIAS_FIRST       = 8'h20;
    localparam logic [7:0] ALIAS_LAST        = 8'h2e;
    // ************************************************************
    // Control field positions and reset values
    // ************************************************************
    localparam int         ADDR_MSB          = 10;
    localparam int         BURST_BIT         = 13;
    localparam int         WRITE_BIT         = 14;
    localparam int         INCR_BIT          = 15;
    localparam logic [15:0] CTRL_RESET       = 16'h0000;
    localparam logic [15:0] DATA_RESET       = 16'h0000;
    localparam logic [15:0] CTRL_WMASK       = 16'he7ff;
    localparam logic [4:0]  BURST_MAX        = 5'h10;
    localparam logic [10:0] MEM_DEPTH        = 11'h320;

    // Register access from the serial decoder
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;

    // Indirect access toward registers or test memories
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        mem_sel;
        logic [10:0] addr;
        logic [15:0] wdata;
    } ind_req_t;
endpackage

//--- core/jpeg_indirect_access_port.sv
// Module: indirect register and test memory access port
//
// Behaviour
// - With control bit 13 set, data port accesses are treated as a burst.
// - A burst holds at most 16 transfers; later ones in it are dropped.
// - With bit 14 set, a data port write goes to the location in bits 10:0.
// - With bit 14 clear, a data port access reads the addressed location.
// - With bit 15 set, the indirect address steps by one after each access.
// - Bit 14, not the access direction, decides whether the target word is read or written.
// - The test memory select routes accesses to registers or the SRAMs.
// - During bursts, offsets 0x20 to 0x2e act as the data port.
// - The indirect address is 11 bits and names the next target location.
`timescale 1ns/10ps
module jpeg_indirect_access_port (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire jiap_pkg::reg_req_t req,
    input  wire logic              burst_end,
    input  wire logic              test_memory_select,
    input  wire logic [15:0]       ind_rdata,
    output logic                   rvalid,
    output logic [15:0]            rdata,
    output jiap_pkg::ind_req_t     ind_req
);
    typedef struct packed {
        logic [15:0]        ctrl_r;
        logic [15:0]        data_r;
        logic [4:0]         count_r;
        logic               rvalid_r;
        logic [15:0]        rdata_r;
        logic               pend_r;
        jiap_pkg::ind_req_t ind_r;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic   is_data;
    logic   is_alias;
    logic   in_burst;
    logic   allowed;

    // Offset decode for the burst aliases of the data port
    function automatic logic alias_hit(input logic [7:0] a);
        alias_hit = (a >= jiap_pkg::ALIAS_FIRST)
                  && (a <= jiap_pkg::ALIAS_LAST);
    endfunction

    // ************************************************************
    // Access decode
    // ************************************************************
    // burst flag from control
    assign in_burst = st_r.ctrl_r[jiap_pkg::BURST_BIT];
    assign is_alias = in_burst && alias_hit(req.addr);
    assign is_data  = (req.addr == jiap_pkg::DATA_OFFSET) || is_alias;
    assign allowed  = !in_burst || (st_r.count_r < jiap_pkg::BURST_MAX);

    // Next state
    always_comb begin
        st_nxt          = st_r;
        st_nxt.rvalid_r = 1'b0;
        st_nxt.ind_r.rd = 1'b0;
        st_nxt.ind_r.wr = 1'b0;
        if (burst_end || !in_burst) begin
            st_nxt.count_r = 5'h00;
        end
        // Capture indirect read data one cycle after the request
        if (st_r.pend_r) begin
            st_nxt.pend_r   = 1'b0;
            st_nxt.data_r   = ind_rdata;
            st_nxt.rdata_r  = ind_rdata;
            st_nxt.rvalid_r = 1'b1;
        end
        if (req.wr && req.addr == jiap_pkg::CTRL_OFFSET) begin
            st_nxt.ctrl_r = req.wdata & jiap_pkg::CTRL_WMASK;
        end else if (req.rd && req.addr == jiap_pkg::CTRL_OFFSET) begin
            st_nxt.rdata_r  = st_r.ctrl_r;
            st_nxt.rvalid_r = 1'b1;
        end else if ((req.rd || req.wr) && is_data && allowed) begin
            // target select follows test memory strap
            st_nxt.ind_r.mem_sel = test_memory_select;
            st_nxt.ind_r.addr    = st_r.ctrl_r[jiap_pkg::ADDR_MSB:0];
            if (in_burst) begin
                st_nxt.count_r = st_r.count_r + 5'h01;
            end
            if (st_r.ctrl_r[jiap_pkg::WRITE_BIT]) begin
                st_nxt.data_r      = req.wr ? req.wdata : st_r.data_r;
                st_nxt.ind_r.wdata = req.wr ? req.wdata : st_r.data_r;
                st_nxt.ind_r.wr    = 1'b1;
                if (req.rd) begin
                    st_nxt.rdata_r  = st_r.data_r;
                    st_nxt.rvalid_r = 1'b1;
                end
            end else begin
                st_nxt.ind_r.rd = 1'b1;
                st_nxt.pend_r   = req.rd;
                if (req.wr) begin
                    st_nxt.data_r = req.wdata;
                end
            end
            if (st_r.ctrl_r[jiap_pkg::INCR_BIT]) begin
                st_nxt.ctrl_r[jiap_pkg::ADDR_MSB:0] =
                    st_r.ctrl_r[jiap_pkg::ADDR_MSB:0] + 11'h001;
            end
        end else if (req.rd) begin
            // Unmapped or refused reads answer zero
            st_nxt.rdata_r  = 16'h0000;
            st_nxt.rvalid_r = 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r        <= '0;
            st_r.ctrl_r <= jiap_pkg::CTRL_RESET;
            st_r.data_r <= jiap_pkg::DATA_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rvalid  = st_r.rvalid_r;
    assign rdata   = st_r.rdata_r;
    assign ind_req = st_r.ind_r;

    // ************************************************************
    // Checks
    // ************************************************************
    // unused bits clear
    chk_unused_bits_zero: assert property (@(posedge ref_clk)
        disable iff (rst)
        (st_r.ctrl_r & ~jiap_pkg::CTRL_WMASK) == 16'h0000)
        else $error("unused control bits set");
    chk_ctrl_readback: assert property (@(posedge ref_clk)
        disable iff (rst)
        req.rd && req.addr == jiap_pkg::CTRL_OFFSET
        |=> rvalid && rdata == $past(st_r.ctrl_r))
        else $error("control read back wrong");
    chk_burst_cap: assert property (@(posedge ref_clk)
        disable iff (rst)
        st_r.count_r <= jiap_pkg::BURST_MAX)
        else $error("burst overrun");
    chk_overrun_drop: assert property (@(posedge ref_clk)
        disable iff (rst)
        (req.rd || req.wr) && is_data && !allowed
        |=> !ind_req.rd && !ind_req.wr)
        else $error("access beyond burst cap forwarded");
    chk_write_through: assert property (@(posedge ref_clk)
        disable iff (rst)
        req.wr && is_data && allowed && st_r.ctrl_r[jiap_pkg::WRITE_BIT]
        |=> ind_req.wr && ind_req.wdata == $past(req.wdata))
        else $error("write not forwarded");
    chk_write_gate: assert property (@(posedge ref_clk)
        disable iff (rst)
        ind_req.wr |-> $past(st_r.ctrl_r[jiap_pkg::WRITE_BIT]))
        else $error("write strobe without write enable");
    chk_read_issue: assert property (@(posedge ref_clk)
        disable iff (rst)
        req.rd && is_data && allowed && !st_r.ctrl_r[jiap_pkg::WRITE_BIT]
        |=> ind_req.rd ##1 rvalid)
        else $error("read not issued");
    chk_read_gate: assert property (@(posedge ref_clk)
        disable iff (rst)
        ind_req.rd |-> !$past(st_r.ctrl_r[jiap_pkg::WRITE_BIT]))
        else $error("read strobe with write enable set");
    chk_auto_incr: assert property (@(posedge ref_clk)
        disable iff (rst)
        (req.rd || req.wr) && is_data && allowed
        && st_r.ctrl_r[jiap_pkg::INCR_BIT]
        |=> st_r.ctrl_r[jiap_pkg::ADDR_MSB:0]
        == $past(st_r.ctrl_r[jiap_pkg::ADDR_MSB:0]) + 11'h001)
        else $error("address not incremented");
    chk_target_addr: assert property (@(posedge ref_clk)
        disable iff (rst)
        (req.rd || req.wr) && is_data && allowed
        |=> ind_req.addr == $past(st_r.ctrl_r[jiap_pkg::ADDR_MSB:0]))
        else $error("indirect address wrong");
    chk_addr_hold: assert property (@(posedge ref_clk)
        disable iff (rst)
        !((req.rd || req.wr) && is_data && allowed)
        && !(req.wr && req.addr == jiap_pkg::CTRL_OFFSET)
        |=> $stable(st_r.ctrl_r))
        else $error("control changed without access");
    chk_mem_select: assert property (@(posedge ref_clk)
        disable iff (rst)
        (req.rd || req.wr) && is_data && allowed
        |=> ind_req.mem_sel == $past(test_memory_select))
        else $error("memory select wrong");
    chk_alias_gate: assert property (@(posedge ref_clk)
        disable iff (rst)
        (req.rd || req.wr) && alias_hit(req.addr) && !in_burst
        |=> !ind_req.wr && !ind_req.rd)
        else $error("alias outside burst");
    chk_refused_zero: assert property (@(posedge ref_clk)
        disable iff (rst)
        req.rd && req.addr != jiap_pkg::CTRL_OFFSET
        && !(is_data && allowed)
        |=> rvalid && rdata == 16'h0000)
        else $error("refused read not zero");
    chk_burst_count: assert property (@(posedge ref_clk)
        disable iff (rst)
        (req.rd || req.wr) && is_data && allowed && in_burst
        && !burst_end
        |=> st_r.count_r == $past(st_r.count_r) + 5'h01)
        else $error("burst count");
    chk_burst_clear: assert property (@(posedge ref_clk)
        disable iff (rst)
        (burst_end || !in_burst) && !((req.rd || req.wr) && is_data && allowed)
        |=> st_r.count_r == 5'h00)
        else $error("burst count not cleared");
    chk_read_data: assert property (@(posedge ref_clk)
        disable iff (rst)
        st_r.pend_r |=> rvalid && rdata == $past(ind_rdata))
        else $error("read data");
    chk_one_strobe: assert property (@(posedge ref_clk)
        disable iff (rst)
        !(ind_req.rd && ind_req.wr))
        else $error("read and write strobes together");
endmodule

//--- dv/ind_target_model.sv
// Model of the target registers and test memories behind the indirect port
`timescale 1ns/10ps
module ind_target_model (
    input  wire logic               ref_clk,
    input  wire jiap_pkg::ind_req_t ind_req,
    output logic [15:0]             ind_rdata
);
    logic [15:0] mem [4096];

    // Both banks start cleared
    initial foreach (mem[i]) mem[i] = 16'h0000;

    // write lands at the edge after the strobe
    always @(posedge ref_clk) begin
        if (ind_req.wr)
            mem[{ind_req.mem_sel, ind_req.addr}] <= ind_req.wdata;
    end

    // read word stands in the strobe cycle; otherwise the inverse
    // shows, so a sample taken a cycle late never passes for an answer
    assign ind_rdata = ind_req.rd ? mem[{ind_req.mem_sel, ind_req.addr}]
                                  : ~mem[{ind_req.mem_sel, ind_req.addr}];
endmodule

//--- dv/jpeg_indirect_access_port_tb.sv
// Self-checking bench for the indirect access port
`timescale 1ns/10ps
module jpeg_indirect_access_port_tb;
    logic               ref_clk;
    logic               rst;
    jiap_pkg::reg_req_t req;
    logic               burst_end;
    logic               test_memory_select;
    logic [15:0]        ind_rdata;
    logic               rvalid;
    logic [15:0]        rdata;
    jiap_pkg::ind_req_t ind_req;
    int                 err_total;
    int                 total_checks;
    int                 i;

    jpeg_indirect_access_port dut (.ref_clk(ref_clk), .rst(rst), .req(req),
        .burst_end(burst_end), .test_memory_select(test_memory_select),
        .ind_rdata(ind_rdata), .rvalid(rvalid), .rdata(rdata),
        .ind_req(ind_req));
    ind_target_model target (.ref_clk(ref_clk), .ind_req(ind_req),
        .ind_rdata(ind_rdata));

    // Free-running 10 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic wrap_up();
        if (err_total == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One request held for a single cycle from a falling edge
    task automatic put(input logic r, input logic [7:0] a,
                       input logic [15:0] d);
        req = {r, ~r, a, d};
        @(negedge ref_clk);
        req = '0;
    endtask

    // Write, then one idle cycle so back-to-back calls never re-drive req
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        put(1'b0, a, d);
        @(negedge ref_clk);
    endtask

    // Read, wait a bounded time for the answer, compare it
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        int n;
        put(1'b1, a, 16'h0000);
        for (n = 0; n < 6 && rvalid !== 1'b1; n++) @(negedge ref_clk);
        if (rvalid !== 1'b1) begin
            err_total++;
            wrap_up();
        end else
            chk(rdata, exp);
        // Idle cycle keeps the next request clear of this answer
        @(negedge ref_clk);
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        rst = 1'b1;
        req = '0;
        burst_end = 1'b0;
        test_memory_select = 1'b0;
        err_total = 0;
        total_checks = 0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        rd(8'h1e, 16'h0000);
        wr(8'h1e, 16'hd805);
        rd(8'h1e, 16'hc005);
        wr(8'h1f, 16'h1234);
        wr(8'h1f, 16'habcd);
        rd(8'h1e, 16'hc007);
        wr(8'h1e, 16'h8005);
        rd(8'h1f, 16'h1234);
        rd(8'h1f, 16'habcd);
        test_memory_select = 1'b1;
        wr(8'h1e, 16'h4005);
        wr(8'h1f, 16'h5555);
        wr(8'h1e, 16'h0005);
        rd(8'h1f, 16'h5555);
        test_memory_select = 1'b0;
        rd(8'h1f, 16'h1234);
        rd(8'h20, 16'h0000);
        // Write burst of 17 through the aliases, last one dropped
        wr(8'h1e, 16'he000);
        for (i = 0; i < 17; i++)
            wr(8'h20 + 8'(i % 15), 16'h0100 + 16'(i));
        burst_end = 1'b1;
        @(negedge ref_clk);
        burst_end = 1'b0;
        rd(8'h1e, 16'he010);
        // Read burst of 17, last one refused
        wr(8'h1e, 16'ha000);
        for (i = 0; i < 17; i++)
            rd(8'h2e - 8'(i % 15), i < 16 ? 16'h0100 + 16'(i) : 16'h0000);
        // Dropped seventeenth write left its word untouched
        wr(8'h1e, 16'h0010);
        rd(8'h1f, 16'h0000);
        // Reset in mid-run returns the control register to zero
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        rd(8'h1e, 16'h0000);
        wrap_up();
    end
endmodule
